//--- hw/dmc_pkg.sv
package dmc_pkg;
	// Timing.
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned FAST_SETTLE_NS = 2000;
	localparam int unsigned FAST_SETTLE_CYC =
		(FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] SWITCH_PERIODS = 3'h4;
	localparam int unsigned STRAP_WAIT = 3;

	// Register byte addresses.
	localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h0;
	localparam logic [3:0] ADDR_FAST_OSC_CTRL = 4'h4;
	localparam logic [3:0] ADDR_MODE_STATUS = 4'h8;

	// clock_select_reg fields.
	localparam int unsigned SEL_LSB = 5;
	localparam int unsigned FAST_KEEP_BIT = 1;
	localparam int unsigned SLOW_KEEP_BIT = 0;
	// fast_osc_ctrl_reg fields.
	localparam int unsigned FREQ_LSB = 2;
	localparam int unsigned STABLE_BIT = 1;
	localparam int unsigned FEN_BIT = 0;
	// Mode status fields.
	localparam int unsigned MODE_LSB = 0;
	localparam int unsigned BUSY_BIT = 3;
	localparam int unsigned APPLIED_LSB = 4;
	localparam int unsigned MISMATCH_BIT = 6;

	// Reset values and codes.
	localparam logic [2:0] SEL_RST = 3'h0;
	localparam logic [2:0] SEL_SUB = 3'h7;
	localparam logic FEN_RST = 1'b1;
	localparam logic [1:0] FREQ_RST = 2'h0;
	localparam logic [2:0] MODE_FAST = 3'h0;
	localparam logic [2:0] MODE_SLOW = 3'h1;
	localparam logic [2:0] MODE_IDLE_SLOW_ONLY = 3'h2;
	localparam logic [2:0] MODE_IDLE_BOTH_CLOCKS = 3'h3;
	localparam logic [2:0] MODE_IDLE_FAST_ONLY = 3'h4;
	localparam logic [2:0] MODE_SLEEP = 3'h5;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAKE,
		ST_IDLE_SLOW_ONLY,
		ST_IDLE_BOTH_CLOCKS,
		ST_IDLE_FAST_ONLY,
		ST_SLEEP
	} dmc_state_t;
endpackage : dmc_pkg

//--- hw/dmc_clock_mode_ctrl.sv
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
// Function
// (R1) Fast oscillator frequency 8, 12 or 16 MHz is set by a config strap.
// (R2) Software sets the frequency field equal to the config strap.
// (R3) Sub clock comes from the slow oscillator, high speed from the fast one.
// (R4) FAST mode divides the high speed clock by 1 to 64, codes 000-110.
// (R5) Select 111 gives SLOW mode on the sub clock with the CPU running.
// (R6) In SLOW mode the fast oscillator follows its enable bit.
// (R7) In FAST and SLOW the CPU, sub clock and slow clock all run.
// (R8) Halt with both keep bits low enters SLEEP; all clocks but slow stop.
// (R9) Halt with slow keep only: sub runs, system clock only for 111.
// (R10) Halt with both keep bits: system, high speed and sub clocks run.
// (R11) Halt with fast keep only: sub off, system clock only for 000-110.
// (R12) Slow oscillator clock runs in every mode, SLEEP included.
// (R13) Oscillator clocks also feed the watchdog and the time base; here both take only the slow oscillator clock.
// (R14) Select decodes 000 undivided up to 110 divide 64, 111 sub; resets 000.
// (R15) Enable or frequency change clears stable, sets it when settled; clearing enable leaves it set while the oscillator keeps running.
// (R16) A select change completes after four current periods plus a target edge.
// (R17) Source switching and gating happen only at clock pulse boundaries.
// (R18) Wake resumes the running mode, restarting the fast oscillator first; with select 111 it resumes without waiting for it.
module dmc_clock_mode_ctrl #(
	parameter int unsigned SETTLE_CYCLES = dmc_pkg::FAST_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic halt,
	input wire logic wake,
	input wire logic [1:0] cfg_freq_opt,
	input wire logic fast_rc_osc,
	input wire logic fast_osc_ready,
	input wire logic slow_rc_osc,
	output logic cpu_run,
	output logic sys_clk_en,
	output logic high_speed_clk_en,
	output logic sub_clk_en,
	output logic slow_osc_clk_en,
	output logic wdt_clk_en,
	output logic tb_clk_en,
	output logic fast_osc_run,
	output logic [1:0] fast_osc_freq
);
	localparam int unsigned SW = $clog2(SETTLE_CYCLES + 1);
	localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYCLES);

	if (SETTLE_CYCLES < 1) begin : g_chk
		$error("SETTLE_CYCLES must be at least one");
	end

	function automatic logic [5:0] div_mask(input logic [2:0] s);
		logic [6:0] m;
		m = (7'h01 << s) - 7'h01;
		return m[5:0];
	endfunction : div_mask

	// Synchronisers: index 0 is the first stage and feeds only index 1.
	logic [1:0] wake_s_q, rdy_s_q, fosc_s_q, sosc_s_q;
	logic [1:0] cfg_s0_q, cfg_s1_q;
	logic fosc_old_q, sosc_old_q;

	dmc_pkg::dmc_state_t st_q, st_d;
	logic [2:0] sel_q, sel_d, cur_q, cur_d, swc_q, swc_d;
	logic fkeep_q, fkeep_d, skeep_q, skeep_d, fen_q, fen_d;
	logic [1:0] freq_q, freq_d, appl_q, appl_d, cfg_q, cfg_d;
	logic [1:0] init_q, init_d;
	logic stable_q, stable_d;
	logic [SW-1:0] settle_q, settle_d;
	logic [5:0] div_q, div_d;
	logic [31:0] rd_q, rd_d;
	logic wait_q, wait_d;
	logic [7:0] out_q, out_d;
	logic [1:0] ofreq_q, ofreq_d;

	logic hs_edge, sub_tick, hs_tick, cur_tick, tgt_tick, osc_on;
	logic acc, wr0;
	logic [2:0] mode;
	logic [31:0] rmux;

	always_comb begin
		hs_edge = fosc_s_q[1] & ~fosc_old_q;
		sub_tick = sosc_s_q[1] & ~sosc_old_q; // (R3)
		hs_tick = hs_edge & stable_q; // (R15)
		cur_tick = (cur_q == dmc_pkg::SEL_SUB) ? sub_tick :
			hs_tick && ((div_q & div_mask(cur_q)) == div_mask(cur_q)); // (R14)
		tgt_tick = (sel_q == dmc_pkg::SEL_SUB) ? sub_tick :
			hs_tick && ((div_q & div_mask(sel_q)) == div_mask(sel_q));
		// Fast oscillator demand per state.
		case (st_q)
			dmc_pkg::ST_RUN: osc_on = fen_q |
				(cur_q != dmc_pkg::SEL_SUB) |
				(sel_q != dmc_pkg::SEL_SUB); // (R6)
			dmc_pkg::ST_WAKE: osc_on = cur_q != dmc_pkg::SEL_SUB; // (R18)
			dmc_pkg::ST_IDLE_BOTH_CLOCKS: osc_on = 1'b1; // (R10)
			dmc_pkg::ST_IDLE_FAST_ONLY: osc_on = 1'b1; // (R11)
			default: osc_on = 1'b0; // (R8) (R9)
		endcase
		case (st_q)
			dmc_pkg::ST_RUN: mode = (cur_q == dmc_pkg::SEL_SUB) ?
				dmc_pkg::MODE_SLOW : dmc_pkg::MODE_FAST;
			dmc_pkg::ST_WAKE: mode = dmc_pkg::MODE_SLEEP;
			dmc_pkg::ST_IDLE_SLOW_ONLY: mode = dmc_pkg::MODE_IDLE_SLOW_ONLY;
			dmc_pkg::ST_IDLE_BOTH_CLOCKS: mode = dmc_pkg::MODE_IDLE_BOTH_CLOCKS;
			dmc_pkg::ST_IDLE_FAST_ONLY: mode = dmc_pkg::MODE_IDLE_FAST_ONLY;
			default: mode = dmc_pkg::MODE_SLEEP;
		endcase
		rmux = 32'h0000_0000;
		case (address)
			dmc_pkg::ADDR_CLOCK_SELECT: begin
				rmux[dmc_pkg::SEL_LSB +: 3] = sel_q;
				rmux[dmc_pkg::FAST_KEEP_BIT] = fkeep_q;
				rmux[dmc_pkg::SLOW_KEEP_BIT] = skeep_q;
			end
			dmc_pkg::ADDR_FAST_OSC_CTRL: begin
				rmux[dmc_pkg::FREQ_LSB +: 2] = freq_q;
				rmux[dmc_pkg::STABLE_BIT] = stable_q;
				rmux[dmc_pkg::FEN_BIT] = fen_q;
			end
			dmc_pkg::ADDR_MODE_STATUS: begin
				rmux[dmc_pkg::MODE_LSB +: 3] = mode;
				rmux[dmc_pkg::BUSY_BIT] = sel_q != cur_q;
				rmux[dmc_pkg::APPLIED_LSB +: 2] = appl_q;
				rmux[dmc_pkg::MISMATCH_BIT] = freq_q != cfg_q;
			end
			default: rmux = 32'h0000_0000;
		endcase
	end

	// Bus, configuration and oscillator settle.
	always_comb begin
		acc = (read | write) & ~wait_q;
		wr0 = write & ~wait_q & byteenable[0];
		wait_d = ~((read | write) & wait_q);
		rd_d = rd_q;
		if ((read | write) & wait_q) begin
			rd_d = rmux;
		end else if (acc) begin
			rd_d = 32'h0000_0000;
		end
		sel_d = sel_q;
		fkeep_d = fkeep_q;
		skeep_d = skeep_q;
		fen_d = fen_q;
		freq_d = freq_q;
		settle_d = settle_q;
		stable_d = stable_q;
		appl_d = appl_q;
		init_d = init_q;
		cfg_d = cfg_q;
		if (init_q != 2'(dmc_pkg::STRAP_WAIT)) begin
			init_d = init_q + 2'h1;
			if (init_d == 2'(dmc_pkg::STRAP_WAIT)) begin
				cfg_d = cfg_s1_q; // (R1)
			end
		end
		if (!osc_on || !rdy_s_q[1]) begin
			settle_d = '0;
			stable_d = 1'b0;
		end else if (settle_q != SETTLE_END) begin
			settle_d = settle_q + 1'b1;
		end else if (!stable_q) begin
			stable_d = 1'b1; // (R15)
			appl_d = freq_q;
		end
		if (wr0 && address == dmc_pkg::ADDR_CLOCK_SELECT) begin
			sel_d = writedata[dmc_pkg::SEL_LSB +: 3];
			fkeep_d = writedata[dmc_pkg::FAST_KEEP_BIT];
			skeep_d = writedata[dmc_pkg::SLOW_KEEP_BIT];
		end
		if (wr0 && address == dmc_pkg::ADDR_FAST_OSC_CTRL) begin
			fen_d = writedata[dmc_pkg::FEN_BIT];
			freq_d = writedata[dmc_pkg::FREQ_LSB +: 2];
			if ((fen_d & ~fen_q) || freq_d != freq_q) begin
				settle_d = '0; // (R15)
				stable_d = 1'b0;
			end
		end
	end

	// Mode sequencing, source switching and clock enables.
	always_comb begin
		st_d = st_q;
		cur_d = cur_q;
		swc_d = swc_q;
		div_d = hs_tick ? div_q + 6'h01 : div_q; // (R4)
		if (sel_q == cur_q) begin
			swc_d = 3'h0;
		end else if (swc_q != dmc_pkg::SWITCH_PERIODS) begin
			if (cur_tick) swc_d = swc_q + 3'h1; // (R16)
		end else if (tgt_tick) begin
			cur_d = sel_q; // (R16) (R17)
			swc_d = 3'h0;
		end
		case (st_q)
			dmc_pkg::ST_RUN: begin
				if (halt) begin
					case ({fkeep_q, skeep_q})
						2'b00: st_d = dmc_pkg::ST_SLEEP; // (R8)
						2'b01: st_d = dmc_pkg::ST_IDLE_SLOW_ONLY; // (R9)
						2'b11: st_d = dmc_pkg::ST_IDLE_BOTH_CLOCKS; // (R10)
						default: st_d = dmc_pkg::ST_IDLE_FAST_ONLY; // (R11)
					endcase
				end
			end
			dmc_pkg::ST_WAKE: begin
				if (cur_q == dmc_pkg::SEL_SUB || stable_q) begin
					st_d = dmc_pkg::ST_RUN; // (R18)
				end
			end
			default: begin
				if (wake_s_q[1]) st_d = dmc_pkg::ST_WAKE; // (R18)
			end
		endcase
		out_d = 8'h00;
		out_d[0] = st_q == dmc_pkg::ST_RUN; // (R7)
		case (st_q)
			dmc_pkg::ST_RUN: begin
				out_d[1] = cur_tick; // (R4) (R5)
				out_d[2] = hs_tick;
				out_d[3] = sub_tick; // (R7)
			end
			dmc_pkg::ST_IDLE_SLOW_ONLY: begin
				out_d[1] = cur_tick & (cur_q == dmc_pkg::SEL_SUB); // (R9)
				out_d[3] = sub_tick;
			end
			dmc_pkg::ST_IDLE_BOTH_CLOCKS: begin
				out_d[1] = cur_tick; // (R10)
				out_d[2] = hs_tick;
				out_d[3] = sub_tick;
			end
			dmc_pkg::ST_IDLE_FAST_ONLY: begin
				out_d[1] = cur_tick & (cur_q != dmc_pkg::SEL_SUB); // (R11)
				out_d[2] = hs_tick;
			end
			default: out_d[1] = 1'b0; // (R8)
		endcase
		out_d[4] = sub_tick; // (R12)
		out_d[5] = sub_tick; // (R13)
		out_d[6] = sub_tick; // (R13)
		out_d[7] = osc_on; // (R3) (R6)
		ofreq_d = cfg_q; // (R1)
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wake_s_q <= 2'h0;
			rdy_s_q <= 2'h0;
			fosc_s_q <= 2'h0;
			sosc_s_q <= 2'h0;
			cfg_s0_q <= 2'h0;
			cfg_s1_q <= 2'h0;
			fosc_old_q <= 1'b0;
			sosc_old_q <= 1'b0;
			st_q <= dmc_pkg::ST_RUN;
			sel_q <= dmc_pkg::SEL_RST; // (R14)
			cur_q <= dmc_pkg::SEL_RST;
			swc_q <= 3'h0;
			fkeep_q <= 1'b0;
			skeep_q <= 1'b0;
			fen_q <= dmc_pkg::FEN_RST;
			freq_q <= dmc_pkg::FREQ_RST;
			appl_q <= dmc_pkg::FREQ_RST;
			cfg_q <= dmc_pkg::FREQ_RST;
			init_q <= 2'h0;
			stable_q <= 1'b0;
			settle_q <= '0;
			div_q <= 6'h00;
			rd_q <= 32'h0000_0000;
			wait_q <= 1'b1;
			out_q <= 8'h00;
			ofreq_q <= dmc_pkg::FREQ_RST;
		end else if (ce) begin
			wake_s_q <= {wake_s_q[0], wake};
			rdy_s_q <= {rdy_s_q[0], fast_osc_ready};
			fosc_s_q <= {fosc_s_q[0], fast_rc_osc};
			sosc_s_q <= {sosc_s_q[0], slow_rc_osc};
			cfg_s0_q <= cfg_freq_opt;
			cfg_s1_q <= cfg_s0_q;
			fosc_old_q <= fosc_s_q[1];
			sosc_old_q <= sosc_s_q[1];
			st_q <= st_d;
			sel_q <= sel_d;
			cur_q <= cur_d;
			swc_q <= swc_d;
			fkeep_q <= fkeep_d;
			skeep_q <= skeep_d;
			fen_q <= fen_d;
			freq_q <= freq_d;
			appl_q <= appl_d;
			cfg_q <= cfg_d;
			init_q <= init_d;
			stable_q <= stable_d;
			settle_q <= settle_d;
			div_q <= div_d;
			rd_q <= rd_d;
			wait_q <= wait_d;
			out_q <= out_d;
			ofreq_q <= ofreq_d;
		end
	end

	// Enables are one-cycle pulses, so gating never cuts a pulse short.
	assign readdata = rd_q;
	assign waitrequest = wait_q;
	assign cpu_run = out_q[0];
	assign sys_clk_en = out_q[1];
	assign high_speed_clk_en = out_q[2];
	assign sub_clk_en = out_q[3];
	assign slow_osc_clk_en = out_q[4];
	assign wdt_clk_en = out_q[5];
	assign tb_clk_en = out_q[6];
	assign fast_osc_run = out_q[7];
	assign fast_osc_freq = ofreq_q;
endmodule : dmc_clock_mode_ctrl

//--- verification/dmc_osc_model.sv
`timescale 1ns/1ns
module dmc_osc_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic fast_osc_run,
	input wire logic [7:0] ready_dly,
	output logic fast_rc_osc,
	output logic slow_rc_osc,
	output logic fast_osc_ready
);
	logic [7:0] wait_q;
	logic [7:0] dly_q;
	logic [5:0] div_q;
	// The delay is latched while stopped, so ready never drops mid-run.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= 6'h00;
			wait_q <= 8'h00;
			dly_q <= 8'h00;
		end else begin
			div_q <= div_q + 6'h01;
			dly_q <= fast_osc_run ? dly_q : ready_dly;
			wait_q <= fast_osc_run ? wait_q + {7'h0, wait_q < dly_q} : 8'h00;
		end
	end
	assign slow_rc_osc = div_q[5];
	assign fast_rc_osc = fast_osc_run && div_q[2];
	assign fast_osc_ready = fast_osc_run && wait_q >= dly_q;
endmodule : dmc_osc_model

//--- verification/dmc_asserts.sv
`timescale 1ns/1ns
module dmc_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic halt,
	input wire logic [1:0] cfg_freq_opt,
	input wire logic cpu_run,
	input wire logic sys_clk_en,
	input wire logic high_speed_clk_en,
	input wire logic sub_clk_en,
	input wire logic slow_osc_clk_en,
	input wire logic wdt_clk_en,
	input wire logic tb_clk_en,
	input wire logic [1:0] fast_osc_freq
);
	logic [2:0] sel_q, sel_d;
	logic [1:0] keep_q, keep_d;
	logic [7:0] slow_q, slow_d, wdt_q, wdt_d, sub_q, sub_d;
	logic [7:0] tbase_q, tbase_d;
	always_comb begin
		sel_d = sel_q;
		keep_d = keep_q;
		if (write && !waitrequest && address == 4'h0) begin
			sel_d = writedata[7:5];
			keep_d = writedata[1:0];
		end
		slow_d = slow_osc_clk_en ? 8'h00 : slow_q + 8'h01;
		wdt_d = wdt_clk_en ? 8'h00 : wdt_q + 8'h01;
		tbase_d = tb_clk_en ? 8'h00 : tbase_q + 8'h01;
		sub_d = (sub_clk_en || !cpu_run) ? 8'h00 : sub_q + 8'h01;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_q <= 3'h0;
			keep_q <= 2'h0;
			slow_q <= 8'h00;
			wdt_q <= 8'h00;
			tbase_q <= 8'h00;
			sub_q <= 8'h00;
		end else begin
			sel_q <= sel_d;
			keep_q <= keep_d;
			slow_q <= slow_d;
			wdt_q <= wdt_d;
			tbase_q <= tbase_d;
			sub_q <= sub_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence halt_s(k);
		cpu_run && halt && keep_q == k;
	endsequence
	bus_ack_a: assert property ((read || write) && waitrequest |=>
		!waitrequest ##1 waitrequest) else $error("bus handshake broken");
	sleep_gate_a: assert property (halt_s(2'h0) |-> ##3 (!cpu_run &&
		!sys_clk_en && !high_speed_clk_en && !sub_clk_en)[*6])
		else $error("clock running in sleep");
	idle_slow_a: assert property (halt_s(2'h1) |-> ##3 (!cpu_run &&
		!high_speed_clk_en && (sel_q == 3'h7 || !sys_clk_en))[*6])
		else $error("wrong clocks in slow idle");
	idle_fast_a: assert property (halt_s(2'h2) |-> ##3 (!cpu_run &&
		!sub_clk_en && (sel_q != 3'h7 || !sys_clk_en))[*6])
		else $error("wrong clocks in fast idle");
	idle_both_a: assert property (halt_s(2'h3) |-> ##3 !cpu_run
		##[1:80] high_speed_clk_en) else $error("no fast tick in idle");
	slow_alive_a: assert property (slow_q < 8'h8c)
		else $error("slow clock stopped");
	wdt_alive_a: assert property (wdt_q < 8'h8c)
		else $error("watchdog clock stopped");
	tb_alive_a: assert property (tbase_q < 8'h8c)
		else $error("time base clock stopped");
	sys_pulse_a: assert property (sys_clk_en |=> !sys_clk_en)
		else $error("system clock pulse stretched");
	run_sub_a: assert property (sub_q < 8'h8c)
		else $error("sub clock stopped while running");
	freq_strap_a: assert property (sub_clk_en |->
		fast_osc_freq == cfg_freq_opt) else $error("strap not followed");
	cover property (halt_s(2'h0));
	cover property (halt_s(2'h3));
	cover property (cpu_run && sel_q == 3'h7 && sys_clk_en);
endmodule : dmc_asserts
bind dmc_clock_mode_ctrl dmc_asserts chk_i (.*);

//--- verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic halt = 1'b0;
	logic wake = 1'b0;
	logic [3:0] address = 4'h0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [1:0] strap = 2'h0;
	logic [7:0] rdy_dly = 8'h02;
	logic [31:0] readdata, rd;
	logic waitrequest, cpu_run, osc_run, fro, sro, rdy;
	logic [2:0] sel;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	dmc_clock_mode_ctrl #(.SETTLE_CYCLES(4)) uut (
		.clk(clk), .rstn(rstn), .ce(1'b1), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hf),
		.readdata(readdata), .waitrequest(waitrequest), .halt(halt),
		.wake(wake), .cfg_freq_opt(strap), .fast_rc_osc(fro),
		.fast_osc_ready(rdy), .slow_rc_osc(sro), .cpu_run(cpu_run),
		.sys_clk_en(), .high_speed_clk_en(), .sub_clk_en(),
		.slow_osc_clk_en(), .wdt_clk_en(), .tb_clk_en(),
		.fast_osc_run(osc_run), .fast_osc_freq());
	dmc_osc_model osc (.clk(clk), .rstn(rstn), .fast_osc_run(osc_run),
		.ready_dly(rdy_dly), .fast_rc_osc(fro), .slow_rc_osc(sro),
		.fast_osc_ready(rdy));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	// Polls status until a pending clock switch has finished.
	task automatic wait_idle;
		do bus(1'b0, 4'h8, 32'h0);
		while (rd[dmc_pkg::BUSY_BIT] !== 1'b0);
	endtask : wait_idle
	function automatic logic [31:0] exp_mode(logic [2:0] s, logic [1:0] k,
		logic h);
		if (!h)
			return (s == 3'h7) ? 32'(dmc_pkg::MODE_SLOW) :
				32'(dmc_pkg::MODE_FAST);
		case (k)
			2'h0: return 32'(dmc_pkg::MODE_SLEEP);
			2'h1: return 32'(dmc_pkg::MODE_IDLE_SLOW_ONLY);
			2'h2: return 32'(dmc_pkg::MODE_IDLE_FAST_ONLY);
			default: return 32'(dmc_pkg::MODE_IDLE_BOTH_CLOCKS);
		endcase
	endfunction : exp_mode
	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h04ff_f648));
		strap <= 2'($urandom_range(2, 0));
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_0000);
		repeat (40) @(posedge clk);
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, 32'h0000_0003);
		bus(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0000_0000);
		bus(1'b1, 4'h4, {28'h0, strap, 2'h1});
		bus(1'b1, 4'h0, 32'h0000_00ff);
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_00e3);
		wait_idle();
		bus(1'b1, 4'h4, {28'h0, strap, 2'h0});
		repeat (4) @(posedge clk);
		chk({31'h0, osc_run}, 32'h0000_0000);
		rdy_dly <= 8'h1e;
		bus(1'b1, 4'h4, {28'h0, strap, 2'h1});
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, {28'h0, strap, 2'h1});
		repeat (60) @(posedge clk);
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, {28'h0, strap, 2'h3});
		bus(1'b0, 4'h8, 32'h0);
		chk(rd, {25'h0, 1'b0, strap, 1'b0, dmc_pkg::MODE_SLOW});
		for (int i = 0; i < 12; i++) begin
			sel = 3'($urandom_range(7, 0));
			rdy_dly <= 8'($urandom_range(30, 1));
			bus(1'b1, 4'h0, {24'h0, sel, 3'h0, 2'(i)});
			wait_idle();
			chk({29'h0, rd[2:0]}, exp_mode(sel, 2'(i), 1'b0));
			halt <= 1'b1;
			@(posedge clk);
			halt <= 1'b0;
			repeat (12) @(posedge clk);
			chk({31'h0, cpu_run}, 32'h0000_0000);
			bus(1'b0, 4'h8, 32'h0);
			chk({29'h0, rd[2:0]}, exp_mode(sel, 2'(i), 1'b1));
			wake <= 1'b1;
			while (cpu_run !== 1'b1) @(posedge clk);
			wake <= 1'b0;
			wait_idle();
			chk({29'h0, rd[2:0]}, exp_mode(sel, 2'(i), 1'b0));
		end
		// A second reset in mid-run must bring back the power-on values.
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, 4'h4, 32'h0);
		chk(rd, 32'h0000_0001);
		bus(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0000_0000);
		give_verdict();
	end
endmodule : tb_top
